/* hw/param_table_reader.sv */
// host side reader of the profile 1 parameter table and register command lookup
`timescale 1ns/1ps
`include "xspi_p1_consts.svh"
module param_table_reader
  import xspi_p1_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `RD_TIMEOUT_CYCLES
)(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // user orders: header words and start
  input  wire logic        start,
  input  wire logic [31:0] headerWord1,
  input  wire logic [31:0] headerWord2,
  // device parameter read port
  output logic             devRdReq,
  output logic [23:0]      devRdAddr,
  input  wire logic        devRdAck,
  input  wire logic [31:0] devRdData,
  // status
  output logic             busy,
  output logic             tableValid,
  output logic             errAlign,
  output logic             errLength,
  output logic             errTimeout,
  output logic             reservedWarn,
  // decoded parameter read format
  output logic             paramAddrLeftJust,
  output logic [4:0]       paramDummyCycles,
  output logic [21:0]      supportFlags,
  // command lookup for the sequencer
  input  wire reg_cmd_e    cmdSel,
  output logic             cmdAllowed,
  output logic [7:0]       cmdOpcode,
  output logic [3:0]       cmdLatency,
  output logic [2:0]       cmdModBytes,
  output logic [1:0]       cmdDataBytes
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_READ,
    ST_WAIT,
    ST_LATCH
  } rd_state_e;

  localparam logic [1:0] LAST_IDX = 2'(`TABLE_WORDS - 2'd1);

  rd_state_e     state;
  rd_state_e     next_state;
  logic [23:0]   tablePtr;
  logic [7:0]    tableLen;
  logic [1:0]    wordIdx;
  logic [31:0]   rawWord [3];
  logic [31:0]   waitCount;
  table_params_s params;
  logic          timeoutHit;

  param_decode_if decIf ();

  assign decIf.word1 = rawWord[0];
  assign decIf.word2 = rawWord[1];
  assign decIf.word3 = rawWord[2];

  param_word_decode decoder (
    .dec (decIf.decoder)
  );

  assign timeoutHit = (waitCount >= TIMEOUT_CYCLES - 1);

  // sequencing of the three word reads
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if ((tablePtr[1:0] != 2'b00) || (tableLen < `MIN_LEN_FIELD)) begin
          next_state = ST_IDLE;
        end else begin
          next_state = ST_READ;
        end
      end
      ST_READ: begin
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (devRdAck) begin
          next_state = (wordIdx == LAST_IDX) ? ST_LATCH : ST_READ;
        end else if (timeoutHit) begin
          next_state = ST_IDLE;
        end
      end
      ST_LATCH: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // header capture: pointer and one-based length
  always_ff @(posedge clock) begin
    if (rst) begin
      tablePtr <= '0;
      tableLen <= '0;
    end else if (state == ST_IDLE && start) begin
      tablePtr <= headerWord2[`HDR_PTR_MSB:`HDR_PTR_LSB];
      tableLen <= headerWord1[`HDR_LEN_MSB:`HDR_LEN_LSB];
    end
  end

  // header checks; a fresh start clears old errors
  always_ff @(posedge clock) begin
    if (rst) begin
      errAlign   <= 1'b0;
      errLength  <= 1'b0;
      errTimeout <= 1'b0;
    end else if (state == ST_IDLE && start) begin
      errAlign   <= 1'b0;
      errLength  <= 1'b0;
      errTimeout <= 1'b0;
    end else begin
      if (state == ST_CHECK) begin
        errAlign  <= (tablePtr[1:0] != 2'b00);
        // three words needed, the field value 3 means three words
        errLength <= (tableLen < `MIN_LEN_FIELD);
      end
      if (state == ST_WAIT && !devRdAck && timeoutHit) begin
        errTimeout <= 1'b1;
      end
    end
  end

  // word index and device read port; reads only, the table is never written
  always_ff @(posedge clock) begin
    if (rst) begin
      wordIdx   <= '0;
      devRdReq  <= 1'b0;
      devRdAddr <= '0;
    end else begin
      case (state)
        ST_CHECK: begin
          wordIdx <= '0;
        end
        ST_READ: begin
          devRdReq  <= 1'b1;
          devRdAddr <= tablePtr + {22'h000000, wordIdx} * `WORD_BYTES;
        end
        ST_WAIT: begin
          if (devRdAck || timeoutHit) begin
            devRdReq <= 1'b0;
          end
          if (devRdAck) begin
            wordIdx <= wordIdx + 2'd1;
          end
        end
        default: begin
          devRdReq <= 1'b0;
        end
      endcase
    end
  end

  // words land in flops; the decoder sees them one cycle later
  always_ff @(posedge clock) begin
    if (rst) begin
      rawWord[0] <= '0;
      rawWord[1] <= '0;
      rawWord[2] <= '0;
    end else if (state == ST_WAIT && devRdAck) begin
      rawWord[wordIdx] <= devRdData;
    end
  end

  // request watchdog so a silent device cannot hang the reader
  always_ff @(posedge clock) begin
    if (rst) begin
      waitCount <= '0;
    end else if (state == ST_WAIT) begin
      waitCount <= waitCount + 32'd1;
    end else begin
      waitCount <= '0;
    end
  end

  // decoded table held once complete
  always_ff @(posedge clock) begin
    if (rst) begin
      params       <= '0;
      tableValid   <= 1'b0;
      reservedWarn <= 1'b0;
    end else if (state == ST_IDLE && start) begin
      tableValid <= 1'b0;
    end else if (state == ST_LATCH) begin
      params       <= decIf.params;
      tableValid   <= 1'b1;
      reservedWarn <= decIf.params.reservedSet;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (next_state != ST_IDLE);
    end
  end

  // parameter read format, only meaningful where that read is offered
  always_ff @(posedge clock) begin
    if (rst) begin
      paramAddrLeftJust <= 1'b0;
      paramDummyCycles  <= `DUMMY_SHORT;
      supportFlags      <= '0;
    end else begin
      supportFlags <= tableValid ? params.support : '0;
      if (tableValid && params.support[`SUP_PARAM_READ - `SUP_FLAG_LSB]) begin
        paramAddrLeftJust <= params.addrLeftJust;
        paramDummyCycles  <= params.paramReadDummy;
      end else begin
        paramAddrLeftJust <= 1'b0;
        paramDummyCycles  <= `DUMMY_SHORT;
      end
    end
  end

  // support lookup per command; status read, fast read, fast read wrap need care
  function automatic logic flagOf(input logic [21:0] sup, input int unsigned pos);
    flagOf = sup[pos - `SUP_FLAG_LSB];
  endfunction

  logic       lookAllowed;
  logic [7:0] lookOpcode;
  logic [3:0] lookLatency;
  logic [2:0] lookModBytes;
  logic [1:0] lookDataBytes;

  always_comb begin
    lookAllowed   = 1'b0;
    lookOpcode    = `OPCODE_NONE;
    lookLatency   = '0;
    lookModBytes  = `MOD_NONE;
    lookDataBytes = '0;
    case (cmdSel)
      CMD_READ_STATUS: begin
        // mandatory, no flag to consult
        lookAllowed  = 1'b1;
        lookLatency  = params.statusLatency;
        lookModBytes = params.statusModBytes;
      end
      CMD_FAST_READ: begin
        lookAllowed = 1'b1;
        lookOpcode  = params.fastReadOp;
      end
      CMD_FAST_READ_WRAP: begin
        lookAllowed = flagOf(params.support, `SUP_FAST_WRAP)
                    && (params.wrapReadOp != `OPCODE_NONE);
        lookOpcode  = lookAllowed ? params.wrapReadOp : `OPCODE_NONE;
      end
      CMD_READ_REG: begin
        lookAllowed  = flagOf(params.support, `SUP_RD_REG);
        lookModBytes = lookAllowed ? params.regReadModBytes : `MOD_NONE;
      end
      CMD_READ_VOL: begin
        lookAllowed = flagOf(params.support, `SUP_RD_VOL);
        lookOpcode  = lookAllowed ? params.volReadOp : `OPCODE_NONE;
        lookLatency = lookAllowed ? params.volReadLatency : '0;
      end
      CMD_READ_NV: begin
        lookAllowed = flagOf(params.support, `SUP_RD_NV);
        lookOpcode  = lookAllowed ? params.nvReadOp : `OPCODE_NONE;
        lookLatency = lookAllowed ? params.nvReadLatency : '0;
      end
      CMD_WRITE_STATUS_CFG: begin
        lookAllowed  = flagOf(params.support, `SUP_WR_SC);
        lookModBytes = lookAllowed ? params.statusCfgModBytes : `MOD_NONE;
      end
      CMD_WRITE_REG: begin
        lookAllowed   = flagOf(params.support, `SUP_WR_REG);
        lookModBytes  = lookAllowed ? params.regWriteModBytes : `MOD_NONE;
        lookDataBytes = lookAllowed ? params.regWriteDataBytes : '0;
      end
      CMD_WRITE_VOL: begin
        lookAllowed = flagOf(params.support, `SUP_WR_VOL);
        lookOpcode  = lookAllowed ? params.volWriteOp : `OPCODE_NONE;
      end
      CMD_WRITE_NV: begin
        lookAllowed = flagOf(params.support, `SUP_WR_NV);
        lookOpcode  = lookAllowed ? params.nvWriteOp : `OPCODE_NONE;
      end
      CMD_PARAM_READ: begin
        lookAllowed = flagOf(params.support, `SUP_PARAM_READ);
        lookLatency = '0;
      end
      default: begin
        lookAllowed = 1'b0;
      end
    endcase
  end

  // nothing is offered before a complete table has been read
  always_ff @(posedge clock) begin
    if (rst) begin
      cmdAllowed   <= 1'b0;
      cmdOpcode    <= `OPCODE_NONE;
      cmdLatency   <= '0;
      cmdModBytes  <= `MOD_NONE;
      cmdDataBytes <= '0;
    end else if (tableValid) begin
      cmdAllowed   <= lookAllowed;
      cmdOpcode    <= lookOpcode;
      cmdLatency   <= lookLatency;
      cmdModBytes  <= lookModBytes;
      cmdDataBytes <= lookDataBytes;
    end else begin
      cmdAllowed   <= 1'b0;
      cmdOpcode    <= `OPCODE_NONE;
      cmdLatency   <= '0;
      cmdModBytes  <= `MOD_NONE;
      cmdDataBytes <= '0;
    end
  end

endmodule

/* hw/param_word_decode.sv */
// combinational field decode of the three parameter words
`timescale 1ns/1ps
`include "xspi_p1_consts.svh"
module param_word_decode
  import xspi_p1_pkg::*;
(
  // raw words and decoded fields
  param_decode_if.decoder dec
);

  logic [31:0] w1;
  logic [31:0] w2;
  logic [31:0] w3;

  assign w1 = dec.word1;
  assign w2 = dec.word2;
  assign w3 = dec.word3;

  always_comb begin
    dec.params = '0;
    dec.params.addrLeftJust      = w1[`W1_ADDR_FMT];
    dec.params.paramReadDummy    = w1[`W1_PRD_DUMMY] ? `DUMMY_LONG : `DUMMY_SHORT;
    dec.params.statusModBytes    = w1[`W1_RDSR_MOD] ? `MOD_FOUR : `MOD_NONE;
    dec.params.statusLatency     = w1[`W1_RDSR_LAT] ? `LAT_LONG : `LAT_SHORT;
    dec.params.regReadModBytes   = w1[`W1_RDREG_MOD] ? `MOD_FOUR : `MOD_ONE;
    dec.params.volReadLatency    = w1[`W1_RDVOL_LAT] ? `LAT_LONG : `LAT_SHORT;
    dec.params.nvReadLatency     = w1[`W1_RDNV_LAT] ? `LAT_LONG : `LAT_SHORT;
    dec.params.statusCfgModBytes = w1[`W1_WRSC_MOD] ? `MOD_FOUR : `MOD_NONE;
    dec.params.regWriteModBytes  = w1[`W1_WRREG_MOD] ? `MOD_FOUR : `MOD_ONE;
    dec.params.regWriteDataBytes = w1[`W1_WRREG_DATA] ? `DATA_TWO : `DATA_ONE;
    dec.params.fastReadOp        = w1[`W1_FAST_MSB:`W1_FAST_LSB];
    dec.params.wrapReadOp        = w1[`W1_WRAP_MSB:`W1_WRAP_LSB];
    dec.params.volReadOp         = w2[`W2_RDVOL_MSB:`W2_RDVOL_LSB];
    dec.params.nvReadOp          = w2[`W2_RDNV_MSB:`W2_RDNV_LSB];
    dec.params.volWriteOp        = w2[`W2_WRVOL_MSB:`W2_WRVOL_LSB];
    dec.params.nvWriteOp         = w2[`W2_WRNV_MSB:`W2_WRNV_LSB];
    // flags kept as one vector, bit 0 is the lowest defined flag
    dec.params.support           = w3[`SUP_PARAM_READ:`SUP_FLAG_LSB];
    // a reserved bit seen set is reported, never acted on
    dec.params.reservedSet       = (|w1[`W1_RSVD_MSB:`W1_RSVD_LSB])
                                 | (|w3[`W3_RSVD_MSB:`W3_RSVD_LSB]);
  end

endmodule

/* inc/param_decode_if.sv */
// raw table words in, decoded parameters out
`timescale 1ns/1ps
interface param_decode_if;
  import xspi_p1_pkg::*;
  logic [31:0]   word1;
  logic [31:0]   word2;
  logic [31:0]   word3;
  table_params_s params;
  modport decoder (input word1, input word2, input word3, output params);
  modport reader  (output word1, output word2, output word3, input params);
endinterface

/* inc/xspi_p1_consts.svh */
// constants for the profile 1 parameter table reader
`ifndef XSPI_P1_CONSTS_SVH
`define XSPI_P1_CONSTS_SVH

// clock and timing
`define CLK_PERIOD_NS      8
`define RD_TIMEOUT_NS      8192
`define RD_TIMEOUT_CYCLES  (`RD_TIMEOUT_NS / `CLK_PERIOD_NS)

// table geometry
`define TABLE_WORDS        2'd3
`define WORD_BYTES         24'h000004
`define HDR_LEN_MSB        31
`define HDR_LEN_LSB        24
`define HDR_PTR_MSB        23
`define HDR_PTR_LSB        0
`define MIN_LEN_FIELD      8'h03

// first word fields
`define W1_ADDR_FMT        31
`define W1_PRD_DUMMY       30
`define W1_RDSR_MOD        29
`define W1_RDSR_LAT        28
`define W1_RDREG_MOD       27
`define W1_RDVOL_LAT       26
`define W1_RDNV_LAT        25
`define W1_WRSC_MOD        24
`define W1_WRREG_MOD       23
`define W1_WRREG_DATA      22
`define W1_RSVD_MSB        21
`define W1_RSVD_LSB        16
`define W1_FAST_MSB        15
`define W1_FAST_LSB        8
`define W1_WRAP_MSB        7
`define W1_WRAP_LSB        0

// second word fields
`define W2_RDVOL_MSB       31
`define W2_RDVOL_LSB       24
`define W2_RDNV_MSB        23
`define W2_RDNV_LSB        16
`define W2_WRVOL_MSB       15
`define W2_WRVOL_LSB       8
`define W2_WRNV_MSB        7
`define W2_WRNV_LSB        0

// third word support flags, bit positions
`define SUP_PARAM_READ     31
`define SUP_FAST_WRAP      30
`define SUP_WRAP_SETUP     29
`define SUP_ERASE_4K       28
`define SUP_ERASE_32K      27
`define SUP_ERASE_CHIP     26
`define SUP_RD_CFG         25
`define SUP_RD_FLAG        24
`define SUP_RD_REG         23
`define SUP_RD_VOL         22
`define SUP_RD_NV          21
`define SUP_WR_SC          20
`define SUP_CLR_FLAG       19
`define SUP_WR_REG         18
`define SUP_WR_VOL         17
`define SUP_WR_NV          16
`define SUP_DPD_ENTER      15
`define SUP_DPD_EXIT       14
`define SUP_SOFT_RST       13
`define SUP_RST_EN         12
`define SUP_RST_DEFPROT    11
`define SUP_DEFPROT        10
`define SUP_FLAG_LSB       10
`define W3_RSVD_MSB        9
`define W3_RSVD_LSB        0

// decoded counts
`define DUMMY_SHORT        5'h08
`define DUMMY_LONG         5'h14
`define LAT_SHORT          4'h4
`define LAT_LONG           4'h8
`define MOD_NONE           3'h0
`define MOD_ONE            3'h1
`define MOD_FOUR           3'h4
`define DATA_ONE           2'h1
`define DATA_TWO           2'h2
`define OPCODE_NONE        8'h00

`endif

/* inc/xspi_p1_pkg.sv */
// types shared by the parameter table reader and its decoder
package xspi_p1_pkg;

  typedef enum logic [3:0] {
    CMD_READ_STATUS,
    CMD_READ_REG,
    CMD_READ_VOL,
    CMD_READ_NV,
    CMD_WRITE_STATUS_CFG,
    CMD_WRITE_REG,
    CMD_WRITE_VOL,
    CMD_WRITE_NV,
    CMD_FAST_READ,
    CMD_FAST_READ_WRAP,
    CMD_PARAM_READ
  } reg_cmd_e;

  typedef struct packed {
    logic       addrLeftJust;
    logic [4:0] paramReadDummy;
    logic [2:0] statusModBytes;
    logic [3:0] statusLatency;
    logic [2:0] regReadModBytes;
    logic [3:0] volReadLatency;
    logic [3:0] nvReadLatency;
    logic [2:0] statusCfgModBytes;
    logic [2:0] regWriteModBytes;
    logic [1:0] regWriteDataBytes;
    logic [7:0] fastReadOp;
    logic [7:0] wrapReadOp;
    logic [7:0] volReadOp;
    logic [7:0] nvReadOp;
    logic [7:0] volWriteOp;
    logic [7:0] nvWriteOp;
    logic [21:0] support;
    logic       reservedSet;
  } table_params_s;

endpackage

/* tb/param_table_device.sv */
// behavioural device holding the three parameter words
`timescale 1ns/1ps
module param_table_device (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // read port from the host
  input  wire logic        devRdReq,
  input  wire logic [23:0] devRdAddr,
  output logic             devRdAck,
  output logic [31:0]      devRdData,
  // contents and behaviour knobs
  input  wire logic [23:0] tableBase,
  input  wire logic [31:0] word1,
  input  wire logic [31:0] word2,
  input  wire logic [31:0] word3,
  input  wire logic [3:0]  ackDelay,
  input  wire logic        mute,
  input  wire logic        leakRsvd
);
  logic [3:0]  waitCnt;
  logic [31:0] pick;
  // no write path exists, so the words can never be altered
  always_comb begin
    if (devRdAddr == tableBase)
      pick = word1 & (leakRsvd ? 32'hffffffff : 32'hffc0ffff);
    else if (devRdAddr == tableBase + 24'h4)
      pick = word2;
    else if (devRdAddr == tableBase + 24'h8)
      pick = word3 & (leakRsvd ? 32'hffffffff : 32'hfffffc00);
    else
      pick = 32'hbad0bad0;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      waitCnt <= 4'h0;
      devRdAck <= 1'b0;
      devRdData <= 32'h5a5a5a5a;
    end else if (devRdReq && !devRdAck && !mute && waitCnt >= ackDelay) begin
      devRdAck <= 1'b1;
      devRdData <= pick;
      waitCnt <= 4'h0;
    end else begin
      devRdAck <= 1'b0;
      // outside the ack cycle the data lines hold nothing trustworthy
      devRdData <= ~devRdData;
      if (devRdReq && !devRdAck) waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

/* tb/param_table_reader_assertions.sv */
// concurrent checks on the parameter table reader ports
`timescale 1ns/1ps
module param_table_reader_assertions
  import xspi_p1_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = 1024
)(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // user side
  input wire logic        start,
  input wire logic [31:0] headerWord1,
  input wire logic [31:0] headerWord2,
  input wire reg_cmd_e    cmdSel,
  // device read port
  input wire logic        devRdReq,
  input wire logic [23:0] devRdAddr,
  input wire logic        devRdAck,
  input wire logic [31:0] devRdData,
  // status and decode
  input wire logic        busy,
  input wire logic        tableValid,
  input wire logic        errAlign,
  input wire logic        errLength,
  input wire logic        errTimeout,
  input wire logic        reservedWarn,
  input wire logic        paramAddrLeftJust,
  input wire logic [4:0]  paramDummyCycles,
  input wire logic [21:0] supportFlags,
  input wire logic        cmdAllowed,
  input wire logic [7:0]  cmdOpcode,
  input wire logic [3:0]  cmdLatency,
  input wire logic [2:0]  cmdModBytes,
  input wire logic [1:0]  cmdDataBytes
);
  logic [31:0] reqRun;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // counts cycles a request waits; only early waits are held to strict standing
  always_ff @(posedge clock) begin
    if (rst || !devRdReq || devRdAck) reqRun <= 32'h0;
    else reqRun <= reqRun + 32'h1;
  end
  a_req_stands: assert property (devRdReq && !devRdAck && reqRun < TIMEOUT_CYCLES / 2
    |=> devRdReq && $stable(devRdAddr)) else $error("read request dropped early");
  a_req_gap: assert property (devRdReq && devRdAck |=> !devRdReq)
    else $error("no idle cycle after ack");
  a_addr_align: assert property (devRdReq |-> devRdAddr[1:0] == 2'b00)
    else $error("unaligned table address");
  a_dummy_pair: assert property (paramDummyCycles == 5'h08 || paramDummyCycles == 5'h14)
    else $error("dummy count outside 8 or 20");
  a_flags_gate: assert property (!tableValid [*2] |-> supportFlags == 22'h0 && !paramAddrLeftJust)
    else $error("flags shown without a table");
  a_lookup_off: assert property (!tableValid [*2] |-> cmdAllowed == 1'b0
    && {cmdOpcode, cmdLatency, cmdModBytes, cmdDataBytes} == 17'h00000) else $error("lookup live");
  a_status_fixed: assert property ($past(cmdSel) == CMD_READ_STATUS && $past(tableValid)
    && tableValid |-> cmdAllowed && cmdLatency inside {4'h4, 4'h8}
    && cmdModBytes inside {3'h0, 3'h4}) else $error("status read lookup wrong");
  a_rdreg_mod: assert property ($past(cmdSel) == CMD_READ_REG && cmdAllowed
    |-> cmdModBytes inside {3'h1, 3'h4} && supportFlags[13]) else $error("read reg wrong");
  a_wrreg_counts: assert property ($past(cmdSel) == CMD_WRITE_REG && cmdAllowed
    |-> cmdModBytes inside {3'h1, 3'h4} && cmdDataBytes inside {2'h1, 2'h2})
    else $error("write reg counts wrong");
  a_wrap_nonzero: assert property ($past(cmdSel) == CMD_FAST_READ_WRAP && cmdAllowed
    |-> cmdOpcode != 8'h00 && supportFlags[20]) else $error("wrap read allowed wrongly");
  a_vol_lat: assert property ($past(cmdSel) == CMD_READ_VOL && cmdAllowed
    |-> cmdLatency inside {4'h4, 4'h8} && supportFlags[12]) else $error("vol read wrong");
  a_nvwr_flag: assert property ($past(cmdSel) == CMD_WRITE_NV && cmdAllowed
    |-> supportFlags[6]) else $error("nv write allowed without flag");
endmodule

/* tb/test_xspi_profile1_param_table.sv */
// self-checking bench for the parameter table reader
`timescale 1ns/1ps
module test_xspi_profile1_param_table;
  import xspi_p1_pkg::*;
  localparam int unsigned TMO = 16;
  logic clock = 1'b0, rst = 1'b1, start, devRdReq, devRdAck, busy, tableValid;
  logic errAlign, errLength, errTimeout, reservedWarn, paramAddrLeftJust, cmdAllowed;
  logic mute, leakRsvd;
  logic [31:0] headerWord1, headerWord2, devRdData, word1, word2, word3, r;
  logic [23:0] devRdAddr, tableBase;
  logic [21:0] supportFlags;
  logic [7:0]  cmdOpcode;
  logic [4:0]  paramDummyCycles;
  logic [3:0]  cmdLatency, ackDelay;
  logic [2:0]  cmdModBytes;
  logic [1:0]  cmdDataBytes;
  reg_cmd_e    cmdSel;
  logic [31:0] rng = 32'hd789;
  int          n_mismatch = 0;
  int          n_compared = 0;

  always #4 clock = ~clock;

  param_table_reader #(.TIMEOUT_CYCLES(TMO)) u_param_table_reader (.clock(clock), .rst(rst),
    .start(start), .headerWord1(headerWord1), .headerWord2(headerWord2), .devRdReq(devRdReq),
    .devRdAddr(devRdAddr), .devRdAck(devRdAck), .devRdData(devRdData), .busy(busy),
    .tableValid(tableValid), .errAlign(errAlign), .errLength(errLength),
    .errTimeout(errTimeout), .reservedWarn(reservedWarn), .paramAddrLeftJust(paramAddrLeftJust),
    .paramDummyCycles(paramDummyCycles), .supportFlags(supportFlags), .cmdSel(cmdSel),
    .cmdAllowed(cmdAllowed), .cmdOpcode(cmdOpcode), .cmdLatency(cmdLatency),
    .cmdModBytes(cmdModBytes), .cmdDataBytes(cmdDataBytes));
  param_table_device u_param_table_device (.clock(clock), .rst(rst), .devRdReq(devRdReq),
    .devRdAddr(devRdAddr), .devRdAck(devRdAck), .devRdData(devRdData), .tableBase(tableBase),
    .word1(word1), .word2(word2), .word3(word3), .ackDelay(ackDelay), .mute(mute),
    .leakRsvd(leakRsvd));

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // packed as allowed, opcode, latency, modifier bytes, data bytes
  function automatic logic [17:0] exp_lookup(input int c, input logic [31:0] a, b, s);
    logic [17:0] e;
    case (c)
      0: e = {1'b1, 8'h00, a[28] ? 4'h8 : 4'h4, a[29] ? 3'h4 : 3'h0, 2'h0};
      1: e = {s[23], 8'h00, 4'h0, a[27] ? 3'h4 : 3'h1, 2'h0};
      2: e = {s[22], b[31:24], a[26] ? 4'h8 : 4'h4, 3'h0, 2'h0};
      3: e = {s[21], b[23:16], a[25] ? 4'h8 : 4'h4, 3'h0, 2'h0};
      4: e = {s[20], 8'h00, 4'h0, a[24] ? 3'h4 : 3'h0, 2'h0};
      5: e = {s[18], 8'h00, 4'h0, a[23] ? 3'h4 : 3'h1, a[22] ? 2'h2 : 2'h1};
      6: e = {s[17], b[15:8], 4'h0, 3'h0, 2'h0};
      7: e = {s[16], b[7:0], 4'h0, 3'h0, 2'h0};
      8: e = {1'b1, a[15:8], 4'h0, 3'h0, 2'h0};
      9: e = {s[30] && a[7:0] != 8'h00, a[7:0], 4'h0, 3'h0, 2'h0};
      default: e = {s[31], 8'h00, 4'h0, 3'h0, 2'h0};
    endcase
    return e[17] ? e : 18'h0;
  endfunction

  task automatic run_table(input logic [23:0] ptr, input logic [7:0] len);
    int i;
    @(negedge clock);
    headerWord1 = {len, 24'h0};
    headerWord2 = {8'h00, ptr};
    tableBase = ptr;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    @(negedge clock);
    i = 0;
    while (busy !== 1'b0 && i < 2000) begin
      @(negedge clock);
      i++;
    end
    if (i == 2000) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  task automatic check_table(input logic valid);
    logic [31:0] a, s;
    a = word1 & (leakRsvd ? 32'hffffffff : 32'hffc0ffff);
    s = word3 & (leakRsvd ? 32'hffffffff : 32'hfffffc00);
    // the gated flag outputs trail tableValid by one register stage
    @(negedge clock);
    check(tableValid, valid);
    if (valid) begin
      check(supportFlags, s[31:10]);
      check(paramAddrLeftJust, s[31] & a[31]);
      check(paramDummyCycles, (s[31] && a[30]) ? 32'd20 : 32'd8);
      check(reservedWarn, (|a[21:16]) || (|s[9:0]));
    end
    for (int c = 0; c < 11; c++) begin
      cmdSel = reg_cmd_e'(c);
      @(negedge clock);
      @(negedge clock);
      check({cmdAllowed, cmdOpcode, cmdLatency, cmdModBytes, cmdDataBytes},
        valid ? exp_lookup(c, a, word2, s) : 18'h0);
    end
  endtask

  initial begin
    start = 1'b0;
    headerWord1 = 32'h0;
    headerWord2 = 32'h0;
    cmdSel = CMD_READ_STATUS;
    {tableBase, word1, word2, word3, ackDelay, mute, leakRsvd} = '0;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    check(paramDummyCycles, 32'd8);
    check(busy, 1'b0);
    check_table(1'b0);
    for (int k = 0; k < 8; k++) begin
      word1 = rnd();
      word2 = rnd();
      word3 = rnd();
      r = rnd();
      if (k == 0) {word1, word3} = '1;
      if (k == 1) {word1, word3} = '0;
      if (k == 2) {word1[7:0], word3[31:30]} = 10'h003;
      leakRsvd = (k == 3);
      ackDelay = r[27:24] % 4'h6;
      run_table({r[23:2], 2'b00}, 8'd3 + {4'h0, r[31:28]});
      check_table(1'b1);
    end
    leakRsvd = 1'b0;
    run_table(24'h000101, 8'd3);
    check(errAlign, 1'b1);
    check_table(1'b0);
    run_table(24'h000100, 8'd2);
    check(errLength, 1'b1);
    check(errAlign, 1'b0);
    // a mute device must end in a timeout, not a hang
    mute = 1'b1;
    run_table(24'h000200, 8'd3);
    check(errTimeout, 1'b1);
    check(tableValid, 1'b0);
    mute = 1'b0;
    ackDelay = 4'h0;
    run_table(24'h000010, 8'd3);
    check(errTimeout, 1'b0);
    check_table(1'b1);
    stop_test();
  end
endmodule

bind param_table_reader param_table_reader_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
  u_param_table_reader_assertions (.clock(clock), .rst(rst), .start(start),
  .headerWord1(headerWord1), .headerWord2(headerWord2), .cmdSel(cmdSel), .devRdReq(devRdReq),
  .devRdAddr(devRdAddr), .devRdAck(devRdAck), .devRdData(devRdData), .busy(busy),
  .tableValid(tableValid), .errAlign(errAlign), .errLength(errLength), .errTimeout(errTimeout),
  .reservedWarn(reservedWarn), .paramAddrLeftJust(paramAddrLeftJust),
  .paramDummyCycles(paramDummyCycles), .supportFlags(supportFlags), .cmdAllowed(cmdAllowed),
  .cmdOpcode(cmdOpcode), .cmdLatency(cmdLatency), .cmdModBytes(cmdModBytes),
  .cmdDataBytes(cmdDataBytes));
